// [hw/tec_timer.sv]
// 8-bit timer/event counter with preload, prescaler, pulse-width mode and apb registers
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module tec_timer (
  input wire logic pclk, // system clock, 250 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [tec_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata_q, // apb read data
  output logic pready_q, // apb ready
  output logic pslverr_q, // apb error on unmapped address
  input wire logic count_pin, // external event / pulse input, asynchronous
  input wire logic cpu_halt, // core is in halt, same clock domain
  input wire logic irq_ack, // interrupt acknowledge pulse from the core
  output logic irq_req_q, // counter interrupt request, level
  output logic wake_q, // one-cycle wake-up request out of halt
  output logic bz_q, // divider output for buzzer pin
  output logic bz_n_q // complement for the paired buzzer pin
);

  // register decode used by read, write and the clock block
  function automatic logic hit(input logic [tec_pkg::ADDR_W-1:0] addr,
                               input logic [5:0] idx);
    hit = (addr[tec_pkg::IDX_MSB:tec_pkg::IDX_LSB] == idx) &&
          (addr[tec_pkg::IDX_LSB-1:0] == 2'b00);
  endfunction

  function automatic logic mapped(input logic [tec_pkg::ADDR_W-1:0] addr);
    mapped = hit(addr, tec_pkg::IDX_IRQ_CONTROL) ||
             hit(addr, tec_pkg::IDX_COUNTER_VALUE) ||
             hit(addr, tec_pkg::IDX_COUNTER_CONTROL);
  endfunction

  tec_pkg::tec_ctrl_t ctrl_q;
  tec_pkg::tec_pw_state_t pw_q;
  logic [7:0] count_q;
  logic [7:0] preload_q;
  logic irq_enable_q;
  logic overflow_flag_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_prev_q;
  logic ps_tick;
  logic access;
  logic complete;
  logic wr_fire;
  logic wr_value;
  logic wr_control;
  logic wr_irq;
  logic rd_block;
  logic pin_rise;
  logic pin_fall;
  logic act_edge;
  logic ret_edge;
  logic cnt_tick;
  logic overflow;
  logic pw_end;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] irq_view;

  // bus handshake
  assign access = psel & penable;
  assign complete = access & pready_q;
  assign wr_fire = complete & pwrite;
  assign wr_value = wr_fire & hit(paddr, tec_pkg::IDX_COUNTER_VALUE);
  assign wr_control = wr_fire & hit(paddr, tec_pkg::IDX_COUNTER_CONTROL);
  assign wr_irq = wr_fire & hit(paddr, tec_pkg::IDX_IRQ_CONTROL);
  assign wbyte = pwdata[7:0];

  // hold the counter still across the whole read so the sampled byte is clean
  assign rd_block = psel & ~pwrite & hit(paddr, tec_pkg::IDX_COUNTER_VALUE);

  tec_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .prescale_sel(ctrl_q.prescale_sel),
    .tick_q(ps_tick)
  );

  // pin synchroniser; only pin_s2_q and later feed logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= count_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign pin_rise = pin_s2_q & ~pin_prev_q;
  assign pin_fall = ~pin_s2_q & pin_prev_q;

  // active edge per polarity; the return edge is the opposite one
  assign act_edge = ctrl_q.count_edge_polarity ? pin_fall : pin_rise;
  assign ret_edge = ctrl_q.count_edge_polarity ? pin_rise : pin_fall;

  // count source per mode
  always_comb begin
    cnt_tick = 1'b0;
    unique case (ctrl_q.mode)
      tec_pkg::TEC_MODE_UNUSED: begin
        cnt_tick = 1'b0;
      end
      tec_pkg::TEC_MODE_EVENT: begin
        cnt_tick = act_edge;
      end
      tec_pkg::TEC_MODE_TIMER: begin
        cnt_tick = ps_tick;
      end
      tec_pkg::TEC_MODE_PULSE: begin
        cnt_tick = ps_tick & (pw_q == tec_pkg::TEC_PW_MEASURE);
      end
    endcase
    if (!ctrl_q.count_run || rd_block) begin
      cnt_tick = 1'b0;
    end
  end

  assign overflow = cnt_tick & (count_q == tec_pkg::COUNT_MAX);

  // measurement ends on the return edge while measuring
  assign pw_end = (pw_q == tec_pkg::TEC_PW_MEASURE) & ret_edge &
                  ctrl_q.count_run & (ctrl_q.mode == tec_pkg::TEC_MODE_PULSE);

  // pulse-width sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_q <= tec_pkg::TEC_PW_WAIT;
    end else if (!ctrl_q.count_run || ctrl_q.mode != tec_pkg::TEC_MODE_PULSE) begin
      pw_q <= tec_pkg::TEC_PW_WAIT;
    end else begin
      unique case (pw_q)
        tec_pkg::TEC_PW_WAIT: begin
          if (act_edge) begin
            pw_q <= tec_pkg::TEC_PW_MEASURE;
          end
        end
        tec_pkg::TEC_PW_MEASURE: begin
          if (ret_edge) begin
            pw_q <= tec_pkg::TEC_PW_WAIT;
          end
        end
      endcase
    end
  end

  // live count; only presetn clears it, warm resets do not reach here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= tec_pkg::COUNT_RESET;
    end else if (wr_value && !ctrl_q.count_run) begin
      count_q <= wbyte;
    end else if (overflow) begin
      count_q <= preload_q;
    end else if (cnt_tick) begin
      count_q <= count_q + tec_pkg::COUNT_STEP;
    end
  end

  // preload register behind the same location as the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload_q <= tec_pkg::COUNT_RESET;
    end else if (wr_value) begin
      preload_q <= wbyte;
    end
  end

  // control register; a software write in the same cycle beats the auto-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tec_pkg::tec_ctrl_t'(tec_pkg::CONTROL_RESET);
    end else if (wr_control) begin
      ctrl_q <= tec_pkg::tec_ctrl_t'(wbyte);
      ctrl_q.unused5 <= 1'b0;
    end else if (pw_end) begin
      ctrl_q.count_run <= 1'b0;
    end
  end

  // interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_q <= 1'b0;
    end else if (wr_irq) begin
      irq_enable_q <= wbyte[tec_pkg::IRQ_ENABLE_BIT];
    end
  end

  // sticky flag; a new overflow wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= 1'b0;
    end else if (overflow) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_irq) begin
      overflow_flag_q <= wbyte[tec_pkg::IRQ_FLAG_BIT];
    end else if (irq_ack) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // request follows flag and enable one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= overflow_flag_q & irq_enable_q;
    end
  end

  // wake request only matters while the core sits in halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= overflow & cpu_halt;
    end
  end

  // buzzer pair, square wave at half the overflow rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bz_q <= 1'b0;
      bz_n_q <= 1'b1;
    end else if (overflow) begin
      bz_q <= ~bz_q;
      bz_n_q <= bz_q;
    end
  end

  // read view of irq_control_reg; other bits read zero
  always_comb begin
    irq_view = tec_pkg::BYTE_ZERO;
    irq_view[tec_pkg::IRQ_ENABLE_BIT] = irq_enable_q;
    irq_view[tec_pkg::IRQ_FLAG_BIT] = overflow_flag_q;
  end

  always_comb begin
    rbyte = tec_pkg::BYTE_ZERO;
    if (hit(paddr, tec_pkg::IDX_COUNTER_VALUE)) begin
      rbyte = count_q;
    end else if (hit(paddr, tec_pkg::IDX_COUNTER_CONTROL)) begin
      rbyte = ctrl_q;
      rbyte[5] = 1'b0;
    end else if (hit(paddr, tec_pkg::IDX_IRQ_CONTROL)) begin
      rbyte = irq_view;
    end
  end

  // one wait state: ready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= access & ~pready_q & ~mapped(paddr);
    end
  end

  // read data sampled while the counter clock is blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= tec_pkg::WORD_ZERO;
    end else if (access && !pready_q && !pwrite) begin
      prdata_q <= {24'h000000, rbyte};
    end else if (complete) begin
      prdata_q <= tec_pkg::WORD_ZERO;
    end
  end

endmodule // tec_timer
`default_nettype wire

// [hw/tec_pkg.sv]
// shared constants, types and register map for the 8-bit timer/event counter
//
// Contract
// - eight-bit up-counter clocked by the pin or the internal clock
// - writing counter_value fills the preload; reading it returns the live count
// - prescale_sel codes 000..111 divide the system clock by 2 up to 256
// - count_edge_polarity 0 counts rising pin edges, 1 counts falling edges
// - count_run high lets the counter count, low halts it
// - control bit 5 is unimplemented and reads zero
// - mode field: 01 event count, 10 timer, 11 pulse width, 00 unused
// - event mode counts pin edges; timer and pulse modes count prescaled ticks
// - event and timer modes count from current contents up to ff, then overflow
// - overflow reloads from preload and sets overflow_flag in the same step
// - pulse mode starts at the active edge, stops on return, clears count_run
// - after one measurement the count holds until software sets count_run again
// - pulse mode starts on pin transitions, never on a static level
// - overflow in pulse mode reloads and raises the request like other modes
// - event and timer modes never clear count_run by themselves
// - a counter overflow wakes the device from halt
// - overflow_irq_enable low suppresses the counter interrupt in every mode
// - with counting off, a preload write also loads the counter
// - with counting on, a write reaches only the preload
// - a software read of the counter blocks its clock meanwhile
// - overflow drives the frequency divider output for the buzzer pins
// - a warm reset during halt leaves counter and control untouched
// - overflow_irq_enable sits at bit 2 of irq_control_reg, 1 enables
`default_nettype none
package tec_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_IRQ_CONTROL = 6'h0b;
  localparam logic [5:0] IDX_COUNTER_VALUE = 6'h0d;
  localparam logic [5:0] IDX_COUNTER_CONTROL = 6'h0e;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 7;
  localparam int unsigned ADDR_W = 8;

  // irq_control_reg layout
  localparam int unsigned IRQ_ENABLE_BIT = 2;
  localparam int unsigned IRQ_FLAG_BIT = 5;

  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  localparam int unsigned PRESCALE_W = 8;
  localparam logic [PRESCALE_W-1:0] PRESCALE_BASE = 8'h02;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 8'h01;

  typedef enum logic [1:0] {
    TEC_MODE_UNUSED = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_PULSE = 2'b11
  } tec_mode_t;

  // counter_control as stored: bit 7..6 mode, 5 unused, 4 run, 3 polarity, 2..0 prescale
  typedef struct packed {
    tec_mode_t mode;
    logic unused5;
    logic count_run;
    logic count_edge_polarity;
    logic [2:0] prescale_sel;
  } tec_ctrl_t;

  typedef enum logic {
    TEC_PW_WAIT = 1'b0,
    TEC_PW_MEASURE = 1'b1
  } tec_pw_state_t;

endpackage
`default_nettype wire

// [hw/tec_prescaler.sv]
// free-running prescaler giving a one-cycle tick every 2..256 system clocks
`timescale 1ns/1ns
`default_nettype none
module tec_prescaler (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [2:0] prescale_sel, // division code
  output logic tick_q // one-cycle tick at the divided rate
);

  logic [tec_pkg::PRESCALE_W-1:0] div_q;
  logic [tec_pkg::PRESCALE_W-1:0] div_mask;

  // low bits that must all be ones: 2^(sel+1) clocks per tick
  always_comb begin
    div_mask = (tec_pkg::PRESCALE_BASE << prescale_sel) - tec_pkg::PRESCALE_ONE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + tec_pkg::PRESCALE_ONE;
    end
  end

  // a sel change mid-period can shorten one period; accepted for simplicity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= &(div_q | ~div_mask);
    end
  end

endmodule // tec_prescaler
`default_nettype wire

// [sim/tec_pin_model.sv]
// partner model: the external signal source on the count pin
`timescale 1ns/1ns
`default_nettype none
module tec_pin_model (
  input wire logic pclk, // system clock
  output logic count_pin // external event or pulse pin
);
  initial count_pin = 1'b0;
  // high held w cycles, low w+1 between pulses; keep w >= 2 so the synchroniser sees every level
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(posedge pclk) count_pin <= 1'b1;
      repeat (w) @(posedge pclk);
      count_pin <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
  task automatic level(input logic v);
    @(posedge pclk) count_pin <= v;
  endtask
endmodule // tec_pin_model
`default_nettype wire

// [sim/tec_timer_properties.sv]
// concurrent checks on the ports of the timer/event counter
`timescale 1ns/1ns
`default_nettype none
module tec_timer_properties (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [tec_pkg::ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata_q, // apb read data
  input wire logic pready_q, // apb ready
  input wire logic pslverr_q, // apb error
  input wire logic count_pin, // event pin
  input wire logic cpu_halt, // core halted
  input wire logic irq_ack, // interrupt acknowledge
  input wire logic irq_req_q, // interrupt request
  input wire logic wake_q, // wake-up pulse
  input wire logic bz_q, // buzzer output
  input wire logic bz_n_q // buzzer complement
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] idx;
  logic mapped;
  assign idx = paddr[tec_pkg::IDX_MSB:tec_pkg::IDX_LSB];
  assign mapped = idx == tec_pkg::IDX_IRQ_CONTROL || idx == tec_pkg::IDX_COUNTER_VALUE ||
    idx == tec_pkg::IDX_COUNTER_CONTROL;
  a_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready held over one cycle");
  a_one_wait: assert property ($rose(penable) && psel |-> !pready_q ##1 pready_q)
    else $error("wait state count wrong");
  a_ready_cause: assert property (pready_q |-> psel && penable && $past(psel && penable))
    else $error("ready without access");
  a_err_map: assert property (pready_q |-> pslverr_q == !mapped)
    else $error("error flag does not match map");
  a_rdata_byte: assert property (prdata_q[31:8] == 24'h000000)
    else $error("read data above byte");
  a_bz_pair: assert property (bz_n_q == !bz_q)
    else $error("buzzer pair not complementary");
  a_wake_halt: assert property (wake_q |-> $past(cpu_halt))
    else $error("wake while not halted");
  a_wake_toggle: assert property (wake_q |-> bz_q != $past(bz_q))
    else $error("wake without divider toggle");
  a_wake_single: assert property (wake_q |=> !wake_q)
    else $error("wake longer than one cycle");
  a_halt_toggle: assert property ($changed(bz_q) && $past(cpu_halt) |-> wake_q)
    else $error("overflow in halt without wake");
endmodule // tec_timer_properties
bind tec_timer tec_timer_properties i_tec_timer_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .count_pin,
  .cpu_halt, .irq_ack, .irq_req_q, .wake_q, .bz_q, .bz_n_q);
`default_nettype wire

// [sim/tec_timer_tb_top.sv]
// register-level testbench for the timer/event counter
`timescale 1ns/1ns
`default_nettype none
module tec_timer_tb_top;
  localparam logic [7:0] A_IRQ = {tec_pkg::IDX_IRQ_CONTROL, 2'b00};
  localparam logic [7:0] A_CNT = {tec_pkg::IDX_COUNTER_VALUE, 2'b00};
  localparam logic [7:0] A_CTL = {tec_pkg::IDX_COUNTER_CONTROL, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, cpu_halt, irq_ack, rerr, bzp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_q, rdat, v;
  logic pready_q, pslverr_q, count_pin, irq_req_q, wake_q, bz_q, bz_n_q;
  int err_count, checks, wk, bzt;
  tec_timer i_tec_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .count_pin, .cpu_halt, .irq_ack, .irq_req_q,
    .wake_q, .bz_q, .bz_n_q);
  tec_pin_model i_tec_pin_model (.pclk, .count_pin);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (wake_q === 1'b1) wk++;
    if (bz_q !== bzp) bzt++;
    bzp = bz_q;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rdat = prdata_q;
    rerr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic inr(input int lo, input int hi);
    chk({31'h0, rdat >= lo && rdat <= hi}, 32'h1);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, cpu_halt, irq_ack, bzp} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, A_CTL, 0); chk(rdat, 32'h08);
    xfer(0, A_IRQ, 0); chk(rdat, 32'h00);
    xfer(0, 8'h3c, 0); chk({31'h0, rerr}, 32'h1);
    xfer(1, A_CTL, 8'hef); xfer(0, A_CTL, 0); chk(rdat, 32'hcf);
    xfer(1, A_CTL, 8'h00); xfer(1, A_CNT, 8'h5a);
    xfer(0, A_CNT, 0); chk(rdat, 32'h5a);
    for (int s = 0; s < 8; s++) begin
      xfer(1, A_CNT, 0);
      xfer(1, A_CTL, {5'b10010, s[2:0]});
      repeat (40 << s) @(posedge pclk);
      xfer(1, A_CTL, {5'b10000, s[2:0]});
      xfer(0, A_CNT, 0); inr(20, 22);
    end
    for (int p = 0; p < 2; p++) begin
      xfer(1, A_CNT, 0);
      xfer(1, A_CTL, {4'b0101, p[0], 3'b000});
      i_tec_pin_model.pulse(3, 3);
      i_tec_pin_model.level(1'b1);
      repeat (6) @(posedge pclk);
      xfer(1, A_CTL, {4'b0100, p[0], 3'b000});
      i_tec_pin_model.level(1'b0);
      xfer(0, A_CNT, 0); chk(rdat, p ? 32'h3 : 32'h4);
    end
    xfer(1, A_CNT, 0); xfer(1, A_CTL, 8'hd0);
    i_tec_pin_model.pulse(1, 40);
    xfer(0, A_CTL, 0); chk(rdat, 32'hc0);
    xfer(0, A_CNT, 0); inr(19, 21);
    v = rdat;
    i_tec_pin_model.pulse(2, 5);
    xfer(0, A_CNT, 0); chk(rdat, v);
    cpu_halt <= 1'b1;
    xfer(1, A_CNT, 8'hfe); xfer(1, A_CTL, 8'h90);
    repeat (40) @(posedge pclk);
    xfer(1, A_CTL, 8'h80);
    chk({31'h0, wk >= 8}, 32'h1);
    chk(bzt, wk);
    xfer(0, A_IRQ, 0); chk(rdat, 32'h20);
    chk({31'h0, irq_req_q}, 32'h0);
    xfer(1, A_IRQ, 8'h24);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_req_q}, 32'h1);
    irq_ack <= 1'b1;
    @(posedge pclk) irq_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    xfer(0, A_IRQ, 0); chk(rdat, 32'h04);
    xfer(1, A_CNT, 0); xfer(1, A_CTL, 8'h97); xfer(1, A_CNT, 8'hf0);
    xfer(1, A_CTL, 8'h87); xfer(0, A_CNT, 0); inr(0, 1);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
endmodule // tec_timer_tb_top
`default_nettype wire
